// File: logic/ubs_pkg.sv
// package of offsets, field layouts and reset values for the boost and swap config bank
package ubs_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] UP_BOOST_OFF   = 8'hF6;
    localparam logic [7:0] DOWN_BOOST_OFF = 8'hF8;
    localparam logic [7:0] SWAP_OFF       = 8'hFA;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int UP_LVL_LSB    = 0;
    localparam int DOWN1_LVL_LSB = 0;
    localparam int DOWN2_LVL_LSB = 2;
    localparam int DOWN3_LVL_LSB = 4;
    localparam int SWAP_LSB      = 0;
    localparam int LVL_W         = 2;
    localparam int NUM_PORTS     = 4;

    // --------------------------------------------------------------
    // writable bit masks (reserved bits are dropped)
    // --------------------------------------------------------------
    localparam logic [7:0] UP_BOOST_MASK   = 8'h03;
    localparam logic [7:0] DOWN_BOOST_MASK = 8'h3F;
    localparam logic [7:0] SWAP_MASK       = 8'h0F;

    // --------------------------------------------------------------
    // reset values: normal drive, no swap
    // --------------------------------------------------------------
    localparam logic [7:0] UP_BOOST_RST   = 8'h00;
    localparam logic [7:0] DOWN_BOOST_RST = 8'h00;
    localparam logic [7:0] SWAP_RST       = 8'h00;

    typedef enum logic [1:0] {
        UBS_BOOST_NONE,
        UBS_BOOST_LOW,
        UBS_BOOST_MEDIUM,
        UBS_BOOST_HIGH
    } ubs_boost_t;

endpackage

// File: logic/ubs_pad_swap.sv
// pad multiplexer that exchanges the d+ and d- functions between the dp and dm pads
`timescale 1ns/1ps

module ubs_pad_swap (
    input  wire logic swap,
    input  wire logic d_plus_out,
    input  wire logic d_plus_oe,
    input  wire logic d_minus_out,
    input  wire logic d_minus_oe,
    output logic      d_plus_in,
    output logic      d_minus_in,
    input  wire logic pad_dp_in,
    input  wire logic pad_dm_in,
    output logic      pad_dp_out,
    output logic      pad_dp_oe,
    output logic      pad_dm_out,
    output logic      pad_dm_oe
);

    // purely combinational routing: the line signals are not sampled on sys_clk,
    // they only pass through the mux, so no synchroniser belongs here
    always_comb begin
        if (swap) begin
            pad_dp_out = d_minus_out;
            pad_dp_oe  = d_minus_oe;
            pad_dm_out = d_plus_out;
            pad_dm_oe  = d_plus_oe;
            d_plus_in  = pad_dm_in;
            d_minus_in = pad_dp_in;
        end else begin
            pad_dp_out = d_plus_out;
            pad_dp_oe  = d_plus_oe;
            pad_dm_out = d_minus_out;
            pad_dm_oe  = d_minus_oe;
            d_plus_in  = pad_dp_in;
            d_minus_in = pad_dm_in;
        end
    end

endmodule

// File: logic/ubs_cfg_bank.sv
// drive boost and pin pair swap configuration bank with per-port pad multiplexers
//
// Summary of operation
// - The upstream register holds a two-bit boost level in bits 1:0 with 00 normal up to 11 high, bits 7:2 reserved.
// - The downstream register holds the port 3 boost level in bits 5:4 with the same coding, bits 7:6 reserved.
// - The downstream register holds the port 2 boost level in bits 3:2, 00 no boost and 01/10/11 low, medium, high.
// - The downstream register holds the port 1 boost level in bits 1:0, 00 meaning normal drive.
// - A swap bit of 0 ties d+ to the dp pad and d- to dm, and a 1 ties d+ to dm and d- to dp.
// - Swap register bit 0 swaps the upstream port and bits 1 to 3 swap downstream ports 1 to 3, bits 7:4 reserved.
`timescale 1ns/1ps

module ubs_cfg_bank (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       cfg_wr_en,
    input  wire logic       cfg_rd_en,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    output logic            cfg_rd_valid,
    output logic      [1:0] upstream_drive_level,
    output logic      [1:0] down1_drive_level,
    output logic      [1:0] down2_drive_level,
    output logic      [1:0] down3_drive_level,
    output logic      [3:0] pin_pair_swap_mask,
    input  wire logic [3:0] xcvr_dplus_out,
    input  wire logic [3:0] xcvr_dplus_oe,
    input  wire logic [3:0] xcvr_dminus_out,
    input  wire logic [3:0] xcvr_dminus_oe,
    output logic      [3:0] xcvr_dplus_in,
    output logic      [3:0] xcvr_dminus_in,
    input  wire logic [3:0] pad_dp_in,
    input  wire logic [3:0] pad_dm_in,
    output logic      [3:0] pad_dp_out,
    output logic      [3:0] pad_dp_oe,
    output logic      [3:0] pad_dm_out,
    output logic      [3:0] pad_dm_oe
);

    // --------------------------------------------------------------
    // access decode
    // --------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    // reserved bits are masked on both write and read so they always read zero
    function automatic logic [7:0] readback(input logic [7:0] addr,
                                            input logic [7:0] up_v,
                                            input logic [7:0] dn_v,
                                            input logic [7:0] sw_v);
        readback = 8'h00;
        if (hit(addr, ubs_pkg::UP_BOOST_OFF)) begin
            readback = up_v & ubs_pkg::UP_BOOST_MASK;
        end else if (hit(addr, ubs_pkg::DOWN_BOOST_OFF)) begin
            readback = dn_v & ubs_pkg::DOWN_BOOST_MASK;
        end else if (hit(addr, ubs_pkg::SWAP_OFF)) begin
            readback = sw_v & ubs_pkg::SWAP_MASK;
        end
    endfunction

    // --------------------------------------------------------------
    // configuration registers
    // --------------------------------------------------------------
    logic [7:0] up_boost_reg;
    logic [7:0] up_boost_next;
    logic [7:0] down_boost_reg;
    logic [7:0] down_boost_next;
    logic [7:0] swap_reg;
    logic [7:0] swap_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rd_valid_reg;
    logic       rd_valid_next;

    always_comb begin
        up_boost_next   = up_boost_reg;
        down_boost_next = down_boost_reg;
        swap_next       = swap_reg;
        if (cfg_wr_en && hit(cfg_addr, ubs_pkg::UP_BOOST_OFF)) begin
            up_boost_next = cfg_wdata & ubs_pkg::UP_BOOST_MASK;
        end
        if (cfg_wr_en && hit(cfg_addr, ubs_pkg::DOWN_BOOST_OFF)) begin
            down_boost_next = cfg_wdata & ubs_pkg::DOWN_BOOST_MASK;
        end
        if (cfg_wr_en && hit(cfg_addr, ubs_pkg::SWAP_OFF)) begin
            swap_next = cfg_wdata & ubs_pkg::SWAP_MASK;
        end
        // a read in the same cycle as a write returns the old contents
        rdata_next    = cfg_rd_en ? readback(cfg_addr, up_boost_reg, down_boost_reg, swap_reg)
                                  : rdata_reg;
        rd_valid_next = cfg_rd_en;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            up_boost_reg   <= ubs_pkg::UP_BOOST_RST;
            down_boost_reg <= ubs_pkg::DOWN_BOOST_RST;
            swap_reg       <= ubs_pkg::SWAP_RST;
            rdata_reg      <= 8'h00;
            rd_valid_reg   <= 1'b0;
        end else begin
            up_boost_reg   <= up_boost_next;
            down_boost_reg <= down_boost_next;
            swap_reg       <= swap_next;
            rdata_reg      <= rdata_next;
            rd_valid_reg   <= rd_valid_next;
        end
    end

    // --------------------------------------------------------------
    // static select outputs
    // --------------------------------------------------------------
    // boost codes above 00 may break compliance levels; the bank does not police that
    assign upstream_drive_level = up_boost_reg[ubs_pkg::UP_LVL_LSB +: ubs_pkg::LVL_W];
    assign down3_drive_level    = down_boost_reg[ubs_pkg::DOWN3_LVL_LSB +: ubs_pkg::LVL_W];
    assign down2_drive_level    = down_boost_reg[ubs_pkg::DOWN2_LVL_LSB +: ubs_pkg::LVL_W];
    assign down1_drive_level    = down_boost_reg[ubs_pkg::DOWN1_LVL_LSB +: ubs_pkg::LVL_W];
    assign pin_pair_swap_mask   = swap_reg[ubs_pkg::SWAP_LSB +: ubs_pkg::NUM_PORTS];
    assign cfg_rdata            = rdata_reg;
    assign cfg_rd_valid         = rd_valid_reg;

    // --------------------------------------------------------------
    // pad multiplexers, index 0 upstream, 1..3 downstream
    // --------------------------------------------------------------
    for (genvar p = 0; p < ubs_pkg::NUM_PORTS; p++) begin : g_port
        ubs_pad_swap u_swap (
            .swap        (pin_pair_swap_mask[p]),
            .d_plus_out  (xcvr_dplus_out[p]),
            .d_plus_oe   (xcvr_dplus_oe[p]),
            .d_minus_out (xcvr_dminus_out[p]),
            .d_minus_oe  (xcvr_dminus_oe[p]),
            .d_plus_in   (xcvr_dplus_in[p]),
            .d_minus_in  (xcvr_dminus_in[p]),
            .pad_dp_in   (pad_dp_in[p]),
            .pad_dm_in   (pad_dm_in[p]),
            .pad_dp_out  (pad_dp_out[p]),
            .pad_dp_oe   (pad_dp_oe[p]),
            .pad_dm_out  (pad_dm_out[p]),
            .pad_dm_oe   (pad_dm_oe[p])
        );
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_up_write;
        cfg_wr_en && cfg_addr == ubs_pkg::UP_BOOST_OFF
            |=> upstream_drive_level == $past(cfg_wdata[1:0]);
    endproperty
    a_up_write: assert property (p_up_write) else $error("upstream level not loaded");

    property p_down3_write;
        cfg_wr_en && cfg_addr == ubs_pkg::DOWN_BOOST_OFF
            |=> down3_drive_level == $past(cfg_wdata[5:4]);
    endproperty
    a_down3_write: assert property (p_down3_write) else $error("port3 level wrong");

    property p_down2_write;
        cfg_wr_en && cfg_addr == ubs_pkg::DOWN_BOOST_OFF
            |=> down2_drive_level == $past(cfg_wdata[3:2]);
    endproperty
    a_down2_write: assert property (p_down2_write) else $error("port2 level wrong");

    property p_down1_write;
        cfg_wr_en && cfg_addr == ubs_pkg::DOWN_BOOST_OFF
            |=> down1_drive_level == $past(cfg_wdata[1:0]);
    endproperty
    a_down1_write: assert property (p_down1_write) else $error("port1 level wrong");

    property p_swap_write;
        cfg_wr_en && cfg_addr == ubs_pkg::SWAP_OFF
            |=> pin_pair_swap_mask == $past(cfg_wdata[3:0]);
    endproperty
    a_swap_write: assert property (p_swap_write) else $error("swap mask not loaded");

    property p_pad_straight;
        !pin_pair_swap_mask[0] |-> pad_dp_out[0] == xcvr_dplus_out[0]
                                   && pad_dm_oe[0] == xcvr_dminus_oe[0]
                                   && xcvr_dplus_in[0] == pad_dp_in[0];
    endproperty
    a_pad_straight: assert property (p_pad_straight) else $error("straight routing wrong");

    property p_pad_crossed;
        pin_pair_swap_mask[3] |-> pad_dm_out[3] == xcvr_dplus_out[3]
                                  && pad_dp_oe[3] == xcvr_dminus_oe[3]
                                  && xcvr_dplus_in[3] == pad_dm_in[3];
    endproperty
    a_pad_crossed: assert property (p_pad_crossed) else $error("crossed routing wrong");

    property p_reserved_zero;
        cfg_rd_en && cfg_addr == ubs_pkg::DOWN_BOOST_OFF ##1 cfg_rd_valid
            |-> cfg_rdata[7:6] == 2'h0 && cfg_rdata[5:0] == $past(down_boost_reg[5:0]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_static_hold;
        !cfg_wr_en |=> $stable(upstream_drive_level) && $stable(pin_pair_swap_mask)
                       && $stable(down1_drive_level) && $stable(down2_drive_level)
                       && $stable(down3_drive_level);
    endproperty
    a_static_hold: assert property (p_static_hold) else $error("select changed without write");

    property p_rd_unmapped;
        cfg_rd_en && cfg_addr != ubs_pkg::UP_BOOST_OFF && cfg_addr != ubs_pkg::DOWN_BOOST_OFF
            && cfg_addr != ubs_pkg::SWAP_OFF |=> cfg_rd_valid && cfg_rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_valid_set;
        cfg_rd_en |=> cfg_rd_valid;
    endproperty
    a_rd_valid_set: assert property (p_rd_valid_set) else $error("read answer missing");

    // a stray answer would let the loader latch a byte it never asked for
    property p_rd_valid_clear;
        !cfg_rd_en |=> !cfg_rd_valid;
    endproperty
    a_rd_valid_clear: assert property (p_rd_valid_clear) else $error("stray read answer");

    c_boost_high: cover property (cfg_wr_en && cfg_addr == ubs_pkg::UP_BOOST_OFF
                                  ##1 upstream_drive_level == 2'h3);
    c_swap_all:   cover property (pin_pair_swap_mask == 4'hF);
    c_read_swap:  cover property (cfg_rd_en && cfg_addr == ubs_pkg::SWAP_OFF
                                  ##1 cfg_rdata != 8'h00);
    c_down_mixed: cover property (down1_drive_level != down3_drive_level);

endmodule

// File: bench/ubs_cfg_loader.sv
// model of the configuration loader that writes and reads bank bytes
`timescale 1ns/1ps

module ubs_cfg_loader (
    input  wire logic       sys_clk,
    output logic            cfg_wr_en,
    output logic            cfg_rd_en,
    output logic      [7:0] cfg_addr,
    output logic      [7:0] cfg_wdata,
    input  wire logic [7:0] cfg_rdata,
    input  wire logic       cfg_rd_valid
);
    initial begin
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        cfg_addr  = 8'h00;
        cfg_wdata = 8'h00;
    end

    // idle address and data are inverted so nothing can live on stale values
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cfg_addr  = a;
        cfg_wdata = d;
        cfg_wr_en = 1'b1;
        @(negedge sys_clk);
        cfg_wr_en = 1'b0;
        cfg_addr  = ~a;
        cfg_wdata = ~d;
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        cfg_addr  = a;
        cfg_rd_en = 1'b1;
        @(negedge sys_clk);
        cfg_rd_en = 1'b0;
        cfg_addr  = ~a;
        d         = cfg_rdata;
        v         = cfg_rd_valid;
    endtask

    // boot load keeps every drive level at normal
    task automatic load_defaults();
        write_byte(ubs_pkg::UP_BOOST_OFF, 8'h00);
        write_byte(ubs_pkg::DOWN_BOOST_OFF, 8'h00);
        write_byte(ubs_pkg::SWAP_OFF, 8'h00);
    endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the boost and swap configuration bank
`timescale 1ns/1ps

module tb_top;
    logic       sys_clk, srst, cfg_wr_en, cfg_rd_en, cfg_rd_valid;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, up_m, dn_m, sw_m, a;
    logic [1:0] upstream_drive_level, down1_drive_level, down2_drive_level, down3_drive_level;
    logic [3:0] pin_pair_swap_mask, xcvr_dplus_out, xcvr_dplus_oe, xcvr_dminus_out;
    logic [3:0] xcvr_dminus_oe, xcvr_dplus_in, xcvr_dminus_in, pad_dp_in, pad_dm_in;
    logic [3:0] pad_dp_out, pad_dp_oe, pad_dm_out, pad_dm_oe;
    logic [31:0] seed = 32'h00015839;
    logic [31:0] r;
    int errors = 0;
    int checks_done = 0;

    ubs_cfg_bank i_ubs_cfg_bank (.sys_clk, .srst, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .upstream_drive_level, .down1_drive_level,
        .down2_drive_level, .down3_drive_level, .pin_pair_swap_mask, .xcvr_dplus_out,
        .xcvr_dplus_oe, .xcvr_dminus_out, .xcvr_dminus_oe, .xcvr_dplus_in, .xcvr_dminus_in,
        .pad_dp_in, .pad_dm_in, .pad_dp_out, .pad_dp_oe, .pad_dm_out, .pad_dm_oe);
    ubs_cfg_loader i_ubs_cfg_loader (.sys_clk, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .cfg_rd_valid);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // unmapped offsets read as zero, reserved bits never stored
    function automatic logic [7:0] exp_rd(input logic [7:0] ad);
        if (ad === ubs_pkg::UP_BOOST_OFF) return up_m;
        if (ad === ubs_pkg::DOWN_BOOST_OFF) return dn_m;
        if (ad === ubs_pkg::SWAP_OFF) return sw_m;
        return 8'h00;
    endfunction

    function automatic logic [3:0] sel(input logic [3:0] s, input logic [3:0] x,
                                       input logic [3:0] y);
        return (~s & x) | (s & y);
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        i_ubs_cfg_loader.write_byte(ad, d);
        if (ad === ubs_pkg::UP_BOOST_OFF) up_m = d & ubs_pkg::UP_BOOST_MASK;
        if (ad === ubs_pkg::DOWN_BOOST_OFF) dn_m = d & ubs_pkg::DOWN_BOOST_MASK;
        if (ad === ubs_pkg::SWAP_OFF) sw_m = d & ubs_pkg::SWAP_MASK;
    endtask

    task automatic rd_chk(input logic [7:0] ad);
        logic [7:0] d;
        logic       v;
        i_ubs_cfg_loader.read_byte(ad, d, v);
        chk_byte({7'h00, v}, 8'h01);
        chk_byte(d, exp_rd(ad));
    endtask

    task automatic check_fields();
        chk_byte({6'h00, upstream_drive_level}, {6'h00, up_m[1:0]});
        chk_byte({6'h00, down1_drive_level}, {6'h00, dn_m[1:0]});
        chk_byte({6'h00, down2_drive_level}, {6'h00, dn_m[3:2]});
        chk_byte({6'h00, down3_drive_level}, {6'h00, dn_m[5:4]});
        chk_byte({4'h0, pin_pair_swap_mask}, sw_m);
    endtask

    task automatic check_pad();
        logic [3:0] s;
        s = sw_m[3:0];
        chk_byte({4'h0, pad_dp_out}, {4'h0, sel(s, xcvr_dplus_out, xcvr_dminus_out)});
        chk_byte({4'h0, pad_dp_oe}, {4'h0, sel(s, xcvr_dplus_oe, xcvr_dminus_oe)});
        chk_byte({4'h0, pad_dm_out}, {4'h0, sel(s, xcvr_dminus_out, xcvr_dplus_out)});
        chk_byte({4'h0, pad_dm_oe}, {4'h0, sel(s, xcvr_dminus_oe, xcvr_dplus_oe)});
        chk_byte({4'h0, xcvr_dplus_in}, {4'h0, sel(s, pad_dp_in, pad_dm_in)});
        chk_byte({4'h0, xcvr_dminus_in}, {4'h0, sel(s, pad_dm_in, pad_dp_in)});
    endtask

    initial begin
        #800000;
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        end_sim();
    end

    initial begin
        srst = 1'b1;
        {xcvr_dplus_out, xcvr_dplus_oe, xcvr_dminus_out, xcvr_dminus_oe} = 16'h0000;
        {pad_dp_in, pad_dm_in} = 8'h00;
        {up_m, dn_m, sw_m} = 24'h000000;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        check_fields();
        chk_byte(cfg_rdata, 8'h00);
        chk_byte({7'h00, cfg_rd_valid}, 8'h00);
        rd_chk(ubs_pkg::UP_BOOST_OFF);
        rd_chk(ubs_pkg::DOWN_BOOST_OFF);
        rd_chk(ubs_pkg::SWAP_OFF);
        rd_chk(8'hF7);
        i_ubs_cfg_loader.load_defaults();
        check_fields();
        $display("test reset done");
        // every code in every field, reserved bits set to prove they are dropped
        for (int i = 0; i < 4; i++) begin
            wr(ubs_pkg::UP_BOOST_OFF, {6'h3F, i[1:0]});
            wr(ubs_pkg::DOWN_BOOST_OFF, {2'h3, i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2});
            wr(ubs_pkg::SWAP_OFF, {4'hF, 4'h1 << i});
            check_fields();
            rd_chk(ubs_pkg::UP_BOOST_OFF);
            rd_chk(ubs_pkg::DOWN_BOOST_OFF);
            rd_chk(ubs_pkg::SWAP_OFF);
        end
        $display("test code sweep done");
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            case (r[9:8])
                2'h0: a = ubs_pkg::UP_BOOST_OFF;
                2'h1: a = ubs_pkg::DOWN_BOOST_OFF;
                2'h2: a = ubs_pkg::SWAP_OFF;
                default: a = r[23:16];
            endcase
            wr(a, r[7:0]);
            check_fields();
            rd_chk(a);
            r = rnd();
            @(negedge sys_clk);
            {xcvr_dplus_out, xcvr_dplus_oe, xcvr_dminus_out, xcvr_dminus_oe} = r[15:0];
            {pad_dp_in, pad_dm_in} = r[23:16];
            #1 check_pad();
        end
        $display("test random done");
        // every field and the read byte nonzero first, so the clear is seen on each of them
        wr(ubs_pkg::UP_BOOST_OFF, 8'hFF);
        wr(ubs_pkg::DOWN_BOOST_OFF, 8'hFF);
        wr(ubs_pkg::SWAP_OFF, 8'hFF);
        check_fields();
        check_pad();
        rd_chk(ubs_pkg::SWAP_OFF);
        @(negedge sys_clk);
        srst = 1'b1;
        @(negedge sys_clk);
        srst = 1'b0;
        {up_m, dn_m, sw_m} = 24'h000000;
        check_fields();
        check_pad();
        chk_byte(cfg_rdata, 8'h00);
        chk_byte({7'h00, cfg_rd_valid}, 8'h00);
        rd_chk(ubs_pkg::DOWN_BOOST_OFF);
        $display("test mid reset done");
        end_sim();
    end
endmodule
